// *** logic/prc_top.sv ***
// Playback dynamic range compressor: APB registers, sample FIFO, gain engine
// Assumes samples and APB come from logic on mclk; one sample pair per word clock
// Contract
// - Bit 6 enables left compression, resets off
// - Bit 5 enables right compression, resets off
// - Threshold code picks -3 to -24 dBFS
// - Hysteresis code gives 0 to 3 dB
// - Hold code zero off, else 32 doubling
// - Hold codes 13, 14, 15 give 3x, 4x, 5x 32768
// - Attack step 4 dB halving per code
// - Decay step 1.5625e-2 dB halving per code
`timescale 1ns/1ps
module prc_top
  import prc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // APB slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [AW-1:0]     paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Playback samples in
  input wire logic              in_valid,
  input wire logic [DATA_W-1:0] in_left,
  input wire logic [DATA_W-1:0] in_right,
  output logic                  in_ready,
  // Compressed samples out
  output logic                  out_valid,
  output logic [DATA_W-1:0]     out_left,
  output logic [DATA_W-1:0]     out_right,
  input wire logic              out_ready
);

  typedef struct packed {
    logic [7:0]                   ctl1;
    logic [7:0]                   ctl2;
    logic [7:0]                   ctl3;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [1:0][GR_W-1:0]         gr;
    logic [1:0][HOLD_W-1:0]       hold;
    logic                         out_valid;
    logic [1:0][DATA_W-1:0]       out_s;
  } prc_state_t;

  localparam prc_state_t ST_RST = '{
    ctl1: CTL1_RST,
    ctl2: CTL2_RST,
    ctl3: CTL3_RST,
    default: '0
  };

  logic                     rst_q1_n;
  logic                     rst_sync_n;
  prc_state_t               r;
  prc_state_t               n;
  logic                     pop;
  logic [1:0]               en;
  logic signed [DATA_W-1:0] in_s    [2];
  logic signed [DATA_W-1:0] gained  [2];
  logic [DATA_W-1:0]        mag     [2];
  logic [1:0]               above;
  logic [1:0]               below;
  logic [GR_W-1:0]          gr_n    [2];
  logic [HOLD_W-1:0]        hold_n  [2];
  logic [DATA_W-1:0]        out_n   [2];
  logic [DATA_W-1:0]        thr_w;
  logic [31:0]              rel_prod;
  logic [DATA_W-1:0]        rel_w;
  logic [GR_W-1:0]          atk_step;
  logic [GR_W-1:0]          dec_step;
  logic [HOLD_W-1:0]        hold_len_w;
  logic [31:0]              rd_mux;
  logic                     addr_ok;
  logic [2:0]               wsel;
  logic                     setup;
  logic                     wr_go;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1_n   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1_n   <= 1'b1;
      rst_sync_n <= rst_q1_n;
    end
  end

  // Pointer arithmetic in the FIFO needs a power-of-two depth of 2 or more
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("prc_top FIFO_DEPTH must be a power of two");
  end

  // Sample FIFO absorbs bursts while the output is stalled
  prc_fifo_if #(.W(2*DATA_W)) deq_if ();

  prc_fifo #(
    .W     (2*DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (mclk),
    .rst_n    (rst_sync_n),
    .in_valid (in_valid),
    .in_data  ({in_right, in_left}),
    .in_ready (in_ready),
    .deq      (deq_if.src)
  );

  // One pair per pop; pop counts as one word-clock period
  assign deq_if.ready = !r.out_valid || out_ready;
  assign pop          = deq_if.valid && deq_if.ready;

  // Channel enables, bit 0 left
  assign en[0] = r.ctl1[EN_L_BIT];
  assign en[1] = r.ctl1[EN_R_BIT];

  // Threshold and release level; hysteresis scales the threshold down
  assign thr_w    = thr_mag(r.ctl1[THR_LSB +: 3]);
  assign rel_prod = thr_w * db_gain({1'b0, r.ctl1[HYS_LSB +: 2]});
  assign rel_w    = rel_prod[30:15];

  // Steps per period, halving with each code
  assign atk_step = GR_W'(1) << (ATK_BASE_SH - 5'(r.ctl3[ATK_LSB +: 4]));
  assign dec_step = GR_W'(1) << (DEC_BASE_SH - 5'(r.ctl3[DEC_LSB +: 4]));

  // Hold length from the table, unlisted codes included
  assign hold_len_w = hold_len(r.ctl2[HOLD_LSB +: 4]);

  // Per-channel gain engine
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [5:0]                db;
    logic [3:0]                sh;
    logic signed [DATA_W+16:0] prod;
    logic signed [DATA_W+16:0] shp;
    logic [GR_W-1:0]           gr_up;
    logic [GR_W-1:0]           gr_dn;

    assign in_s[c] = deq_if.data[c*DATA_W +: DATA_W];

    // Whole dB split into 6 dB shifts and a fine factor; 6 dB is taken
    // as one halving, a 0.3 percent error traded for no divider chain
    assign db   = r.gr[c][GR_W-1 -: 6];
    assign sh   = 4'(db / 6'h6);
    assign prod = in_s[c] * $signed({1'b0, db_gain(3'(db % 6'h6))});
    assign shp  = prod >>> (5'hf + 5'(sh));
    assign gained[c] = shp[DATA_W-1:0];

    // Level is measured after the gain so attack stops at threshold
    assign mag[c]   = gained[c][DATA_W-1] ? DATA_W'(-gained[c]) : DATA_W'(gained[c]);
    assign above[c] = mag[c] > thr_w;
    assign below[c] = mag[c] < rel_w;

    // Saturating step arithmetic
    assign gr_up = (r.gr[c] > GR_MAX - atk_step) ? GR_MAX : r.gr[c] + atk_step;
    assign gr_dn = (r.gr[c] < dec_step) ? '0 : r.gr[c] - dec_step;

    // Attack while above; decay only once below release and hold is spent
    assign gr_n[c] = !pop ? r.gr[c] :
                     !en[c] ? '0 :
                     above[c] ? gr_up :
                     (below[c] && r.hold[c] == '0) ? gr_dn :
                     r.gr[c];
    assign hold_n[c] = !pop ? r.hold[c] :
                       !en[c] ? '0 :
                       above[c] ? hold_len_w :
                       (below[c] && r.hold[c] != '0) ? r.hold[c] - HOLD_W'(1) :
                       r.hold[c];

    // Disabled channel passes the sample untouched
    assign out_n[c] = en[c] ? gained[c] : in_s[c];
  end

  // Address decode and read data
  always_comb begin
    rd_mux  = '0;
    addr_ok = 1'b1;
    wsel    = 3'h0;
    case (paddr)
      byte_addr(CTL1_IDX): begin
        rd_mux = 32'(r.ctl1);
        wsel   = 3'h1;
      end
      byte_addr(CTL2_IDX): begin
        rd_mux = 32'(r.ctl2);
        wsel   = 3'h2;
      end
      byte_addr(CTL3_IDX): begin
        rd_mux = 32'(r.ctl3);
        wsel   = 3'h4;
      end
      byte_addr(STAT_IDX): begin
        rd_mux[5:0]                 = r.gr[0][GR_W-1 -: 6];
        rd_mux[STAT_GR_R +: 6]      = r.gr[1][GR_W-1 -: 6];
        rd_mux[STAT_HOLD_L]         = r.hold[0] != '0;
        rd_mux[STAT_HOLD_L + 1]     = r.hold[1] != '0;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // No wait state: pready is raised by the setup phase
  assign setup = psel && !penable;
  assign wr_go = psel && penable && r.pready && pwrite && !r.pslverr && pstrb[0];

  // Next state: bus side, then sample side
  always_comb begin
    n = r;
    n.pready  = setup;
    n.pslverr = setup && !addr_ok;
    if (setup)
      n.prdata = rd_mux;
    // Reserved bits stay zero whatever is written
    if (wr_go && wsel[0])
      n.ctl1 = pwdata[7:0] & CTL1_WMASK;
    if (wr_go && wsel[1])
      n.ctl2 = pwdata[7:0] & CTL2_WMASK;
    if (wr_go && wsel[2])
      n.ctl3 = pwdata[7:0];
    for (int c = 0; c < 2; c++) begin
      n.gr[c]   = gr_n[c];
      n.hold[c] = hold_n[c];
      if (pop)
        n.out_s[c] = out_n[c];
    end
    if (pop)
      n.out_valid = 1'b1;
    else if (out_ready)
      n.out_valid = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      r <= ST_RST;
    else
      r <= n;
  end

  // Outputs straight from the state flops
  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign out_valid = r.out_valid;
  assign out_left  = r.out_s[0];
  assign out_right = r.out_s[1];

  // Checks on the gain engine and control decode
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence over_s(int c);
    pop && en[c] && above[c];
  endsequence

  sequence quiet_s(int c);
    pop && en[c] && below[c] && r.hold[c] == '0;
  endsequence

  sequence waiting_s(int c);
    pop && en[c] && below[c] && r.hold[c] != '0;
  endsequence

  left_bypass_a:
    assert property (pop && !en[0] |=> r.out_s[0] == $past(in_s[0]) && r.gr[0] == '0)
    else $error("left bypass not transparent");

  right_bypass_a:
    assert property (pop && !en[1] |=> r.out_s[1] == $past(in_s[1]) && r.gr[1] == '0)
    else $error("right bypass not transparent");

  thresh_code_a:
    assert property (r.ctl1[THR_LSB +: 3] == 3'h0 |-> thr_w == 16'h5a9d)
    else $error("threshold code 0 not -3 dBFS");

  hyst_band_a:
    assert property (pop && en[0] && !above[0] && !below[0] |=> $stable(r.gr[0]))
    else $error("gain moved inside hysteresis band");

  hold_load_a:
    assert property (over_s(0) |=> r.hold[0] == $past(hold_len_w))
    else $error("hold not reloaded on attack");

  hold_short_a:
    assert property (r.ctl2[HOLD_LSB +: 4] == 4'h5 |-> hold_len_w == 18'h00200)
    else $error("hold code 5 not 512 periods");

  hold_long_a:
    assert property (r.ctl2[HOLD_LSB +: 4] == 4'hf |-> hold_len_w == 18'h28000)
    else $error("hold code 15 not 5 x 32768");

  hold_table_a:
    assert property ((r.ctl2[HOLD_LSB +: 4] == 4'h0) == (hold_len_w == '0))
    else $error("hold disable code mismatch");

  attack_step_a:
    assert property (over_s(0) && r.gr[0][GR_W-1 -: 6] < 6'h3b
                     |=> r.gr[0] - $past(r.gr[0]) == $past(atk_step))
    else $error("attack step wrong");

  decay_step_a:
    assert property (quiet_s(0) && r.gr[0] >= dec_step
                     |=> $past(r.gr[0]) - r.gr[0] == $past(dec_step))
    else $error("decay step wrong");

  hold_wait_a:
    assert property (waiting_s(0) |=> $stable(r.gr[0]) ##0
                     r.hold[0] == $past(r.hold[0]) - HOLD_W'(1))
    else $error("decay started before hold expired");

  right_band_a:
    assert property (pop && en[1] && !above[1] && !below[1] |=> $stable(r.gr[1]))
    else $error("right gain moved inside hysteresis band");

  right_hold_load_a:
    assert property (over_s(1) |=> r.hold[1] == $past(hold_len_w))
    else $error("right hold not reloaded on attack");

  right_attack_a:
    assert property (over_s(1) && r.gr[1][GR_W-1 -: 6] < 6'h3b
                     |=> r.gr[1] - $past(r.gr[1]) == $past(atk_step))
    else $error("right attack step wrong");

  right_decay_a:
    assert property (quiet_s(1) && r.gr[1] >= dec_step
                     |=> $past(r.gr[1]) - r.gr[1] == $past(dec_step))
    else $error("right decay step wrong");

  right_hold_wait_a:
    assert property (waiting_s(1) |=> $stable(r.gr[1]) ##0
                     r.hold[1] == $past(r.hold[1]) - HOLD_W'(1))
    else $error("right decay started before hold expired");

endmodule : prc_top

// *** logic/prc_pkg.sv ***
// Constants, register map and lookup functions of the range compressor
// Assumes 16-bit signed playback samples and 8-bit control registers
package prc_pkg;

  // Sample and gain-state widths
  localparam int DATA_W = 16;
  localparam int GR_W   = 27;  // Gain reduction, dB with 21 fraction bits
  localparam int HOLD_W = 18;
  localparam int AW     = 12;
  localparam logic [GR_W-1:0] GR_MAX = 27'h7e00000;  // 63 dB ceiling

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTL1_IDX = 8'h44;
  localparam logic [7:0] CTL2_IDX = 8'h45;
  localparam logic [7:0] CTL3_IDX = 8'h46;
  localparam logic [7:0] STAT_IDX = 8'h47;

  // Field positions
  localparam int EN_L_BIT    = 6;
  localparam int EN_R_BIT    = 5;
  localparam int THR_LSB     = 2;
  localparam int HYS_LSB     = 0;
  localparam int HOLD_LSB    = 3;
  localparam int ATK_LSB     = 4;
  localparam int DEC_LSB     = 0;
  localparam int STAT_GR_R   = 8;
  localparam int STAT_HOLD_L = 16;

  // Reset values and writable-bit masks
  localparam logic [7:0] CTL1_RST   = 8'h0f;
  localparam logic [7:0] CTL2_RST   = 8'h38;
  localparam logic [7:0] CTL3_RST   = 8'h00;
  localparam logic [7:0] CTL1_WMASK = 8'h7f;
  localparam logic [7:0] CTL2_WMASK = 8'h78;

  // Step shifts: 4 dB and 1.5625e-2 dB in the 21-bit fraction format
  localparam logic [4:0] ATK_BASE_SH = 5'h17;
  localparam logic [4:0] DEC_BASE_SH = 5'h0f;

  // Hold units in word-clock periods
  localparam int HOLD_UNIT = 32;
  localparam int HOLD_LONG = 32768;

  function automatic logic [AW-1:0] byte_addr(logic [7:0] idx);
    return AW'({idx, 2'h0});
  endfunction : byte_addr

  // Threshold as a linear magnitude against full scale 32767
  function automatic logic [DATA_W-1:0] thr_mag(logic [2:0] c);
    case (c)
      3'h0: return 16'h5a9d;
      3'h1: return 16'h4027;
      3'h2: return 16'h2d6b;
      3'h3: return 16'h2027;
      3'h4: return 16'h16c3;
      3'h5: return 16'h101d;
      3'h6: return 16'h0b68;
      default: return 16'h0813;
    endcase
  endfunction : thr_mag

  // Linear factor of 0 to 5 dB attenuation, 0x8000 is unity
  function automatic logic [15:0] db_gain(logic [2:0] d);
    case (d)
      3'h0: return 16'h8000;
      3'h1: return 16'h7215;
      3'h2: return 16'h65ac;
      3'h3: return 16'h5a9d;
      3'h4: return 16'h50c3;
      default: return 16'h47fb;
    endcase
  endfunction : db_gain

  // Hold length; codes 6..12 continue the doubling, then steps of 32768
  function automatic logic [HOLD_W-1:0] hold_len(logic [3:0] c);
    if (c == 4'h0)
      return '0;
    else if (c <= 4'hb)
      return HOLD_W'(HOLD_UNIT << (c - 4'h1));
    else
      return HOLD_W'((int'(c) - 10) * HOLD_LONG);
  endfunction : hold_len

endpackage : prc_pkg

// *** logic/prc_fifo_if.sv ***
// Carrier between the sample FIFO and the gain engine
// Assumes both ends on the same clock
`timescale 1ns/1ps
interface prc_fifo_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : prc_fifo_if

// *** logic/prc_fifo.sv ***
// Synchronous sample FIFO with valid/ready on both sides
// Assumes a synchronised active-low reset on the same clock
`timescale 1ns/1ps
module prc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // Fill side
  input wire logic         in_valid,
  input wire logic [W-1:0] in_data,
  output logic             in_ready,
  // Drain side
  prc_fifo_if.src          deq
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("prc_fifo DEPTH must be a power of two");
  end

  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
    logic        rdy;
  } prc_fifo_st_t;

  prc_fifo_st_t r;
  prc_fifo_st_t n;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pull;
  logic [PW:0]  cnt_n;

  // Handshakes; extra pointer bit tells full from empty
  assign push      = in_valid && r.rdy;
  assign pull      = deq.valid && deq.ready;
  assign deq.valid = r.wp != r.rp;
  assign deq.data  = mem[r.rp[PW-1:0]];
  assign in_ready  = r.rdy;

  // Ready is registered so the source sees a clean flop
  always_comb begin
    n = r;
    n.wp = r.wp + (PW+1)'(push);
    n.rp = r.rp + (PW+1)'(pull);
    cnt_n = n.wp - n.rp;
    n.rdy = cnt_n != (PW+1)'(DEPTH);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      r <= '{rdy: 1'b1, default: '0};
    else
      r <= n;
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push)
      mem[r.wp[PW-1:0]] <= in_data;
  end

endmodule : prc_fifo

// *** sim/prc_sample_src.sv ***
// Upstream playback sample source for the range compressor bench
// Assumes the bench calls send in order, one pair at a time, on mclk
`timescale 1ns/1ps
module prc_sample_src
  import prc_pkg::*;
(
  // Clock
  input wire logic          clk,
  // Sample port
  output logic              valid,
  output logic [DATA_W-1:0] left,
  output logic [DATA_W-1:0] right,
  input wire logic          ready
);
  initial begin
    valid = 1'b0;
    left  = '0;
    right = '0;
  end

  // Hold the pair until taken; idle lines show the inverse so stale data never matches
  task automatic send(input logic [DATA_W-1:0] l, input logic [DATA_W-1:0] r);
    @(posedge clk);
    valid <= 1'b1;
    left  <= l;
    right <= r;
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    left  <= ~l;
    right <= ~r;
  endtask : send
endmodule : prc_sample_src

// *** sim/test_playback_range_compressor.sv ***
// Self-checking bench of the range compressor: APB registers and sample stream
// Assumes prc_top on one 125 MHz clock and the sample source model beside it
`timescale 1ns/1ps
module test_playback_range_compressor
  import prc_pkg::*;
;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic in_valid, in_ready, out_valid, out_ready, err, drain;
  logic [DATA_W-1:0] in_left, in_right, out_left, out_right, el, er, last_c;
  logic [7:0] v;
  logic [DATA_W-1:0] exp_l[$], exp_r[$];
  int bad_count, n_checks, cycles, cmp_ch, n;

  prc_top #(.FIFO_DEPTH(32)) dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_left(in_left), .in_right(in_right), .in_ready(in_ready), .out_valid(out_valid),
    .out_left(out_left), .out_right(out_right), .out_ready(out_ready));
  prc_sample_src src_u (.clk(mclk), .valid(in_valid), .left(in_left), .right(in_right),
    .ready(in_ready));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= byte_addr(idx);
    pwdata  <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rd_chk

  task automatic put(input logic [DATA_W-1:0] l, input logic [DATA_W-1:0] r);
    exp_l.push_back(l);
    exp_r.push_back(r);
    src_u.send(l, r);
  endtask : put

  // Reference stream: exact in bypass, bounded on the compressed channel
  always @(posedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_l.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        el = exp_l.pop_front();
        er = exp_r.pop_front();
        if (cmp_ch == 1) begin
          last_c = out_left;
          chk({31'h0, $signed(out_left) <= $signed(el)}, 32'h1);
        end else begin
          chk({16'h0, out_left}, {16'h0, el});
        end
        if (cmp_ch == 2) begin
          last_c = out_right;
          chk({31'h0, $signed(out_right) <= $signed(er)}, 32'h1);
        end else begin
          chk({16'h0, out_right}, {16'h0, er});
        end
      end
    end
  end

  // Random sink stalls while draining; hang guard
  always @(posedge mclk) begin
    out_ready <= drain && ($urandom_range(3, 0) != 0);
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'hea3768b0));
    {psel, penable, pwrite, drain} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    cmp_ch = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(CTL1_IDX, 32'h0f);
    rd_chk(CTL2_IDX, 32'h38);
    rd_chk(CTL3_IDX, 32'h00);
    apb(1'b1, CTL1_IDX, 8'hff);
    rd_chk(CTL1_IDX, 32'h7f);
    apb(1'b1, CTL2_IDX, 8'h78);
    rd_chk(CTL2_IDX, 32'h78);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      apb(1'b1, CTL3_IDX, v);
      rd_chk(CTL3_IDX, {24'h0, v});
    end
    // Write with the low byte strobe off must leave the register alone
    pstrb <= 4'h0;
    apb(1'b1, CTL3_IDX, ~v);
    pstrb <= 4'hf;
    rd_chk(CTL3_IDX, {24'h0, v});
    // Unmapped place answers with an error and reads zero
    apb(1'b0, 8'h50, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, CTL1_IDX, 8'h0f);
    apb(1'b1, CTL2_IDX, 8'h38);
    apb(1'b1, CTL3_IDX, 8'h00);
    // Fill the FIFO against a stalled sink until it refuses
    for (n = 0; n < 40; n++) begin
      repeat (2) @(posedge mclk);
      if (in_ready !== 1'b1)
        break;
      put(16'($urandom), 16'($urandom));
    end
    chk(32'(n), 32'h21); // 32 in the FIFO plus one in the output stage
    drain <= 1'b1;
    while (exp_l.size() != 0) @(posedge mclk);
    // Each channel alone: one 4 dB attack lands below -3 dBFS, the 3 dB band
    // then freezes gain and hold until quiet input lets the hold run out
    for (int ch = 1; ch <= 2; ch++) begin
      apb(1'b1, CTL2_IDX, 8'h08);
      apb(1'b1, CTL1_IDX, (ch == 1) ? 8'h43 : 8'h23);
      cmp_ch = ch;
      repeat (20) put(16'h7fff, 16'h7fff);
      while (exp_l.size() != 0) @(posedge mclk);
      chk({31'h0, last_c < 16'h7fff}, 32'h1);
      apb(1'b0, STAT_IDX, 8'h00);
      chk({26'h0, 6'(rd >> (8 * (ch - 1)))}, 32'h4);
      chk({31'h0, rd[15 + ch]}, 32'h1);
      // Hold of 32 periods, then 16 decay steps of 1/64 dB
      repeat (48) put(16'h0000, 16'h0000);
      while (exp_l.size() != 0) @(posedge mclk);
      apb(1'b0, STAT_IDX, 8'h00);
      chk({26'h0, 6'(rd >> (8 * (ch - 1)))}, 32'h3);
      chk({31'h0, rd[15 + ch]}, 32'h0);
      apb(1'b1, CTL1_IDX, 8'h0f);
      put(16'h7fff, 16'h7fff);
      while (exp_l.size() != 0) @(posedge mclk);
      cmp_ch = 0;
      repeat (4) put(16'($urandom), 16'($urandom));
      while (exp_l.size() != 0) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    chk({31'h0, out_valid}, 32'h0);
    // Reset in mid-run returns the control registers to their defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(CTL1_IDX, 32'h0f);
    rd_chk(CTL2_IDX, 32'h38);
    conclude();
  end
endmodule : test_playback_range_compressor
